// ===== common/pmr_params.svh
// constants for the phy management register bank: addresses, field positions, reset values, frame counts
`ifndef PMR_PARAMS_SVH
`define PMR_PARAMS_SVH
// What this block does
// - status shows fixed 100/10 full/half abilities
// - four-pair ability bit always reads zero
// - autoneg complete bit follows negotiation, resets zero
// - fiber far-end fault bit shows partner fault
// - autoneg ability bit reads constant one
// - link bit follows link state, resets zero
// - extended, preamble suppression, jabber bits read zero
// - writable pause advertisement bit, default one
// - five writable mode advertisement bits, default one except the four-pair bit
// - selector reads 0x01; next page, remote fault zero
// - partner pause ability captured, read-only, reset zero
// - partner duplex abilities captured, read-only, reset zero
// - write one starts cable test; self-clears
// - enable reading zero means results valid
// - result code: normal, open, short, failed
// - flag marks short closer than ten metres
// - nine-bit fault distance count, 0.4 m steps
// - answers phy addresses 1,2; registers 1-5,1D, all others read zero

// ****************************************
// register addresses and phy addresses
// ****************************************
`define PMR_REG_STATUS 5'h01
`define PMR_REG_ID_HIGH 5'h02
`define PMR_REG_ID_LOW 5'h03
`define PMR_REG_ADV 5'h04
`define PMR_REG_LP 5'h05
`define PMR_REG_CABLE 5'h1D
`define PMR_PHY_ADDR_ONE 5'h01
`define PMR_PHY_ADDR_TWO 5'h02

// ****************************************
// status register fields
// ****************************************
`define PMR_ST_T4 15
`define PMR_ST_100FD 14
`define PMR_ST_100HD 13
`define PMR_ST_10FD 12
`define PMR_ST_10HD 11
`define PMR_ST_RSV_HI 10
`define PMR_ST_RSV_LO 7
`define PMR_ST_PRE_SUP 6
`define PMR_ST_AN_DONE 5
`define PMR_ST_FAR_FAULT 4
`define PMR_ST_AN_ABLE 3
`define PMR_ST_LINK 2
`define PMR_ST_JABBER 1
`define PMR_ST_EXT 0

// ****************************************
// advertisement, partner and cable fields
// ****************************************
`define PMR_ADV_HI 10
`define PMR_ADV_LO 5
`define PMR_ADV_RESET 6'h2F
`define PMR_ADV_SELECTOR 5'h01
`define PMR_LP_LOW 5'h01
`define PMR_CD_EN 15
`define PMR_CDT_NORMAL 2'h0
`define PMR_CDT_OPEN 2'h1
`define PMR_CDT_SHORT 2'h2
`define PMR_CDT_FAILED 2'h3

// ****************************************
// management frame counts
// ****************************************
`define PMR_PREAMBLE_BITS 6'h20
`define PMR_HDR_LAST 5'h0D
`define PMR_DATA_LAST 5'h0F
`define PMR_START_CODE 2'h1
`define PMR_OP_READ 2'h2
`define PMR_OP_WRITE 2'h1

`endif

// ===== common/pmr_pkg.sv
// types shared by the phy management register bank
package pmr_pkg;
    // management frame phases
    typedef enum logic [1:0] {st_preamble, st_header, st_turn, st_data} pmr_state_type;
    typedef logic [15:0] pmr_word_type;
    typedef logic [4:0] pmr_addr_type;
endpackage

// ===== design/pmr_sync2.sv
// two-flop synchroniser for pins from outside the clock domain
module pmr_sync2 #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // async in, synced out
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // first stage feeds only the second
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;
endmodule // pmr_sync2

// ===== design/pmr_phy_regs.sv
// register set of one embedded phy: status, identifiers, advertisement, partner ability, cable test
`include "pmr_params.svh"
module pmr_phy_regs
    import pmr_pkg::*;
#(
    parameter logic [15:0] ID_HIGH = 16'hA5C3, // arbitrary value
    parameter logic [15:0] ID_LOW = 16'h3C5A // arbitrary value
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // management access
    input wire pmr_addr_type reg_addr_i,
    input wire logic wr_stb_i,
    input wire pmr_word_type wr_data_i,
    output pmr_word_type rd_data_o,
    // line state from phy logic
    input wire logic link_up_i,
    input wire logic an_done_i,
    input wire logic fiber_mode_i,
    input wire logic far_fault_i,
    input wire logic lp_capture_i,
    input wire logic [4:0] lp_ability_i,
    // cable test front end
    input wire logic cable_done_i,
    input wire logic [1:0] cable_result_i,
    input wire logic cable_short_i,
    input wire logic [8:0] cable_count_i,
    output logic cable_start_o,
    // advertised abilities to negotiation
    output logic [5:0] adv_ability_o
);
    logic link_ff, an_ff, fef_ff, cd_en_ff, short_ff;
    logic [5:0] adv_ff;
    logic [4:0] lp_ff;
    logic [1:0] res_ff;
    logic [8:0] cnt_ff;
    logic nxt_cd_en;
    pmr_word_type status_word, adv_word, lp_word, cable_word;
    logic wr_adv, wr_cable, start;

    // ****************************************
    // write decode
    // ****************************************
    assign wr_adv = wr_stb_i && (reg_addr_i == `PMR_REG_ADV);
    assign wr_cable = wr_stb_i && (reg_addr_i == `PMR_REG_CABLE);
    assign start = wr_cable && wr_data_i[`PMR_CD_EN] && (!cd_en_ff || cable_done_i);
    assign nxt_cd_en = start ? 1'b1 : (cable_done_i ? 1'b0 : cd_en_ff);

    // status sampling, advertisement and capture
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            link_ff <= 1'b0;
            an_ff <= 1'b0;
            fef_ff <= 1'b0;
            adv_ff <= `PMR_ADV_RESET;
            lp_ff <= 5'h00;
            cd_en_ff <= 1'b0;
            res_ff <= `PMR_CDT_NORMAL;
            short_ff <= 1'b0;
            cnt_ff <= 9'h000;
        end else begin
            link_ff <= link_up_i;
            an_ff <= an_done_i;
            fef_ff <= fiber_mode_i && far_fault_i;
            if (wr_adv) adv_ff <= wr_data_i[`PMR_ADV_HI:`PMR_ADV_LO];
            if (lp_capture_i) lp_ff <= lp_ability_i;
            cd_en_ff <= nxt_cd_en;
            if (cable_done_i && cd_en_ff) begin
                res_ff <= cable_result_i;
                short_ff <= cable_short_i;
                cnt_ff <= cable_count_i;
            end
        end
    end

    // ****************************************
    // read words
    // ****************************************
    assign status_word[`PMR_ST_T4] = 1'b0;
    assign status_word[`PMR_ST_100FD] = 1'b1;
    assign status_word[`PMR_ST_100HD] = 1'b1;
    assign status_word[`PMR_ST_10FD] = 1'b1;
    assign status_word[`PMR_ST_10HD] = 1'b1;
    assign status_word[`PMR_ST_RSV_HI:`PMR_ST_RSV_LO] = 4'h0;
    assign status_word[`PMR_ST_PRE_SUP] = 1'b0;
    assign status_word[`PMR_ST_AN_DONE] = an_ff;
    assign status_word[`PMR_ST_FAR_FAULT] = fef_ff;
    assign status_word[`PMR_ST_AN_ABLE] = 1'b1;
    assign status_word[`PMR_ST_LINK] = link_ff;
    assign status_word[`PMR_ST_JABBER] = 1'b0;
    assign status_word[`PMR_ST_EXT] = 1'b0;
    assign adv_word = {5'h00, adv_ff, `PMR_ADV_SELECTOR};
    assign lp_word = {5'h00, lp_ff[4], 1'b0, lp_ff[3:0], `PMR_LP_LOW};
    assign cable_word = {cd_en_ff, res_ff, short_ff, 3'h0, cnt_ff};

    // identifiers are constants, unlisted addresses read zero
    assign rd_data_o = (reg_addr_i == `PMR_REG_STATUS) ? status_word :
                       (reg_addr_i == `PMR_REG_ID_HIGH) ? ID_HIGH :
                       (reg_addr_i == `PMR_REG_ID_LOW) ? ID_LOW :
                       (reg_addr_i == `PMR_REG_ADV) ? adv_word :
                       (reg_addr_i == `PMR_REG_LP) ? lp_word :
                       (reg_addr_i == `PMR_REG_CABLE) ? cable_word : 16'h0000;
    assign cable_start_o = start;
    assign adv_ability_o = adv_ff;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    cable_start_a: assert property (start |=> cd_en_ff && cable_word[`PMR_CD_EN])
        else $error("cable test enable not set after start");
    cable_clear_a: assert property (cd_en_ff && cable_done_i && !start |=> !cd_en_ff ##1 !cd_en_ff [*2])
        else $error("cable test enable did not self clear");
    result_latch_a: assert property (cd_en_ff && cable_done_i |=> res_ff == $past(cable_result_i)
        && cnt_ff == $past(cable_count_i)) else $error("cable results not captured");
    link_follow_a: assert property (status_word[`PMR_ST_LINK] == $past(link_up_i))
        else $error("link bit does not follow link state");
    status_fixed_a: assert property (status_word[15:11] == 5'h0F && status_word[3:0] == {1'b1, link_ff, 2'b00})
        else $error("fixed status ability bits wrong");
    adv_write_a: assert property (wr_adv |=> adv_word[10:5] == $past(wr_data_i[10:5])
        && adv_word[4:0] == 5'h01) else $error("advertisement write not stored");
    partner_hold_a: assert property (!lp_capture_i |=> lp_ff == $past(lp_ff))
        else $error("partner ability changed without capture");
endmodule // pmr_phy_regs

// ===== design/pmr_mii_mgmt.sv
// management frame slave and register bank for the two embedded phys
`include "pmr_params.svh"
module pmr_mii_mgmt
    import pmr_pkg::*;
#(
    parameter logic [4:0] PHY_ADDR_ONE = `PMR_PHY_ADDR_ONE,
    parameter logic [4:0] PHY_ADDR_TWO = `PMR_PHY_ADDR_TWO,
    parameter logic [5:0] PREAMBLE_BITS = `PMR_PREAMBLE_BITS
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    // management pins
    input wire logic mdc_i,
    input wire logic mdio_i,
    output logic mdio_o,
    output logic mdio_oe_o,
    // line state, bit 0 for port one, bit 1 for port two; partner ability bits 4:0 for port one, 9:5 for port two
    input wire logic [1:0] link_up_i,
    input wire logic [1:0] an_done_i,
    input wire logic [1:0] fiber_mode_i,
    input wire logic [1:0] far_fault_i,
    input wire logic [1:0] lp_capture_i,
    input wire logic [9:0] lp_ability_i,
    // cable test front end
    input wire logic [1:0] cable_done_i,
    input wire logic [3:0] cable_result_i,
    input wire logic [1:0] cable_short_i,
    input wire logic [17:0] cable_count_i,
    output logic [1:0] cable_start_o,
    // advertised abilities
    output logic [11:0] adv_ability_o
);
    // ****************************************
    // parameter checks
    // ****************************************
    generate
        if (PHY_ADDR_ONE == PHY_ADDR_TWO) begin : g_bad_addr
            $error("the two phy addresses must differ");
        end
        if (PREAMBLE_BITS == 6'h00) begin : g_bad_pre
            $error("preamble length must be at least one bit");
        end
    endgenerate

    // address match for one of the two phys
    function automatic logic phy_hit(input pmr_addr_type addr, input logic idx);
        phy_hit = (addr == (idx ? PHY_ADDR_TWO : PHY_ADDR_ONE));
    endfunction

    // synchronised pins and edge finder
    logic [1:0] pins_s;
    logic mdc_s;
    logic mdio_s;
    logic mdc_prev_ff;
    logic mdc_rise;

    // sequencer registers and their next values
    pmr_state_type state_ff;
    pmr_state_type nxt_state;
    logic [5:0] pre_cnt_ff;
    logic [5:0] nxt_pre_cnt;
    logic [4:0] bit_cnt_ff;
    logic [4:0] nxt_bit_cnt;
    logic [13:0] hdr_ff;
    logic [13:0] nxt_hdr;
    pmr_word_type shift_ff;
    pmr_word_type nxt_shift;

    // pin drive and write strobe
    logic oe_ff;
    logic nxt_oe;
    logic out_ff;
    logic nxt_out;
    logic wr_stb_ff;
    logic nxt_wr_stb;

    // header decode and read selection
    logic [13:0] hdr_in;
    logic frame_ok;
    logic read_op;
    logic hit_any;
    logic hit_two;
    pmr_addr_type phy_addr;
    pmr_addr_type reg_addr;
    pmr_word_type rd_data [2];
    pmr_word_type rd_sel;

    // ****************************************
    // pin sampling
    // ****************************************
    pmr_sync2 #(.WIDTH(2)) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n_i),
        .async_i({mdc_i, mdio_i}),
        .sync_o(pins_s)
    );
    assign mdc_s = pins_s[1];
    assign mdio_s = pins_s[0];

    // management clock edge finder
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            mdc_prev_ff <= 1'b0;
        end else begin
            mdc_prev_ff <= mdc_s;
        end
    end
    assign mdc_rise = mdc_s && !mdc_prev_ff;

    // ****************************************
    // frame decode
    // ****************************************
    assign hdr_in = {hdr_ff[12:0], mdio_s};
    assign frame_ok = (hdr_in[13:12] == `PMR_START_CODE) &&
                      ((hdr_in[11:10] == `PMR_OP_READ) || (hdr_in[11:10] == `PMR_OP_WRITE));
    assign read_op = (hdr_ff[11:10] == `PMR_OP_READ);
    assign phy_addr = hdr_ff[9:5];
    assign reg_addr = hdr_ff[4:0];
    assign hit_two = phy_hit(phy_addr, 1'b1);
    assign hit_any = phy_hit(phy_addr, 1'b0) || hit_two;

    // read word of the addressed phy
    assign rd_sel = hit_two ? rd_data[1] : rd_data[0];

    // ****************************************
    // frame sequencer, advances on management clock rises
    // ****************************************
    always_comb begin
        nxt_state = state_ff;
        nxt_pre_cnt = pre_cnt_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_hdr = hdr_ff;
        nxt_shift = shift_ff;
        nxt_oe = oe_ff;
        nxt_out = out_ff;
        nxt_wr_stb = 1'b0;
        if (mdc_rise) begin
            case (state_ff)
                st_preamble: begin
                    // full preamble always required, no suppression
                    if (mdio_s) begin
                        if (pre_cnt_ff != PREAMBLE_BITS) begin
                            nxt_pre_cnt = pre_cnt_ff + 6'h01;
                        end
                    end else begin
                        if (pre_cnt_ff == PREAMBLE_BITS) begin
                            nxt_state = st_header;
                            nxt_bit_cnt = 5'h01;
                            nxt_hdr = 14'h0000;
                        end
                        nxt_pre_cnt = 6'h00;
                    end
                end
                st_header: begin
                    nxt_hdr = hdr_in;
                    nxt_bit_cnt = bit_cnt_ff + 5'h01;
                    if (bit_cnt_ff == `PMR_HDR_LAST) begin
                        nxt_bit_cnt = 5'h00;
                        nxt_state = frame_ok ? st_turn : st_preamble;
                    end
                end
                st_turn: begin
                    if (bit_cnt_ff == 5'h00) begin
                        // second turnaround bit driven low by us
                        if (read_op && hit_any) begin
                            nxt_oe = 1'b1;
                            nxt_out = 1'b0;
                            nxt_shift = rd_sel;
                        end
                        nxt_bit_cnt = 5'h01;
                    end else begin
                        if (read_op && hit_any) begin
                            nxt_out = shift_ff[15];
                            nxt_shift = {shift_ff[14:0], 1'b0};
                        end
                        nxt_bit_cnt = 5'h00;
                        nxt_state = st_data;
                    end
                end
                st_data: begin
                    if (read_op) begin
                        nxt_out = shift_ff[15];
                        nxt_shift = {shift_ff[14:0], 1'b0};
                    end else begin
                        nxt_shift = {shift_ff[14:0], mdio_s};
                    end
                    nxt_bit_cnt = bit_cnt_ff + 5'h01;
                    if (bit_cnt_ff == `PMR_DATA_LAST) begin
                        nxt_state = st_preamble;
                        nxt_bit_cnt = 5'h00;
                        nxt_oe = 1'b0;
                        nxt_out = 1'b0;
                        nxt_wr_stb = !read_op && hit_any;
                    end
                end
                default: begin
                    nxt_state = st_preamble;
                    nxt_bit_cnt = 5'h00;
                    nxt_oe = 1'b0;
                end
            endcase
        end
    end

    // sequencer state
    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            state_ff <= st_preamble;
            pre_cnt_ff <= 6'h00;
            bit_cnt_ff <= 5'h00;
            hdr_ff <= 14'h0000;
            shift_ff <= 16'h0000;
            oe_ff <= 1'b0;
            out_ff <= 1'b0;
            wr_stb_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            pre_cnt_ff <= nxt_pre_cnt;
            bit_cnt_ff <= nxt_bit_cnt;
            hdr_ff <= nxt_hdr;
            shift_ff <= nxt_shift;
            oe_ff <= nxt_oe;
            out_ff <= nxt_out;
            wr_stb_ff <= nxt_wr_stb;
        end
    end

    assign mdio_o = out_ff;
    assign mdio_oe_o = oe_ff;

    // ****************************************
    // per-phy register sets
    // ****************************************
    generate
        for (genvar i = 0; i < 2; i++) begin : g_phy
            pmr_phy_regs u_regs (
                .sys_clk_i(sys_clk_i),
                .rst_n_i(rst_n_i),
                .reg_addr_i(reg_addr),
                .wr_stb_i(wr_stb_ff && phy_hit(phy_addr, 1'(i))),
                .wr_data_i(shift_ff),
                .rd_data_o(rd_data[i]),
                .link_up_i(link_up_i[i]),
                .an_done_i(an_done_i[i]),
                .fiber_mode_i(fiber_mode_i[i]),
                .far_fault_i(far_fault_i[i]),
                .lp_capture_i(lp_capture_i[i]),
                .lp_ability_i(lp_ability_i[i*5 +: 5]),
                .cable_done_i(cable_done_i[i]),
                .cable_result_i(cable_result_i[i*2 +: 2]),
                .cable_short_i(cable_short_i[i]),
                .cable_count_i(cable_count_i[i*9 +: 9]),
                .cable_start_o(cable_start_o[i]),
                .adv_ability_o(adv_ability_o[i*6 +: 6])
            );
        end
    endgenerate

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);

    // frame phases seen by the checks
    sequence s_read_turn;
        mdc_rise && state_ff == st_turn && bit_cnt_ff == 5'h00 && read_op && hit_any;
    endsequence

    sequence s_frame_end;
        mdc_rise && state_ff == st_data && bit_cnt_ff == `PMR_DATA_LAST;
    endsequence

    sequence s_pre_done;
        mdc_rise && state_ff == st_preamble && !mdio_s && pre_cnt_ff == PREAMBLE_BITS;
    endsequence

    // pin ownership and frame end
    turn_low_a: assert property (s_read_turn |=> mdio_oe_o && !mdio_o)
        else $error("turnaround not driven low on read");
    drive_owner_a: assert property (mdio_oe_o |-> read_op && hit_any &&
        (state_ff == st_turn || state_ff == st_data)) else $error("pin driven outside own read");
    release_end_a: assert property (s_frame_end |=> !mdio_oe_o && state_ff == st_preamble)
        else $error("pin not released at frame end");
    write_once_a: assert property (s_frame_end and (!read_op && hit_any) |=> wr_stb_ff ##1 !wr_stb_ff)
        else $error("write strobe not single pulse");
    foreign_quiet_a: assert property (state_ff == st_turn && !hit_any |-> !mdio_oe_o)
        else $error("answered a foreign phy address");
    preamble_full_a: assert property (state_ff == st_preamble && nxt_state == st_header
        |-> pre_cnt_ff == PREAMBLE_BITS) else $error("frame taken without full preamble");

    // header entry, write ownership and read data path
    hdr_enter_a: assert property (s_pre_done |=> state_ff == st_header && bit_cnt_ff == 5'h01)
        else $error("header not entered after preamble");
    pre_count_a: assert property (state_ff != st_preamble |-> pre_cnt_ff == 6'h00)
        else $error("preamble count not cleared in frame");
    write_owner_a: assert property (wr_stb_ff |-> hit_any && !read_op)
        else $error("write strobe without own write frame");
    read_latch_a: assert property (s_read_turn |=> shift_ff == $past(rd_sel))
        else $error("read word not latched at turnaround");
    data_shift_a: assert property (mdc_rise && state_ff == st_data && read_op &&
        bit_cnt_ff != `PMR_DATA_LAST |=> mdio_o == $past(shift_ff[15])) else $error("read bit out of order");
endmodule // pmr_mii_mgmt

// ===== sim/pmr_mdio_host.sv
// behavioural station management controller driving the management pins
module pmr_mdio_host (
    // clock
    input wire logic sys_clk_i,
    // device side of the data pin
    input wire logic mdio_o,
    input wire logic mdio_oe_o,
    // pins toward the device
    output logic mdc_o,
    output logic mdio_pin_o
);
    timeunit 1ns;
    timeprecision 1ns;

    logic drive_ff = 1'b0;
    logic val_ff = 1'b1;

    initial mdc_o = 1'b0;

    // wire level: device first, then host, else the pull-up
    assign mdio_pin_o = mdio_oe_o ? mdio_o : (drive_ff ? val_ff : 1'b1);

    // one whole frame; mdc stands low between frames, host releases the pin from turnaround on reads
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] bits;
        logic s;
        bits = {32'hFFFF_FFFF, 2'b01, op, pa, ra, 2'b10, wd};
        rd = 16'h0000;
        for (int i = 0; i < 64; i++) begin
            drive_ff <= !(op == 2'b10 && i >= 46);
            val_ff <= bits[63-i];
            repeat (4) @(posedge sys_clk_i);
            s = mdio_pin_o;
            mdc_o <= 1'b1;
            if (i >= 48) rd[63-i] = s;
            repeat (4) @(posedge sys_clk_i);
            mdc_o <= 1'b0;
        end
        @(posedge sys_clk_i);
        drive_ff <= 1'b0;
    endtask
endmodule // pmr_mdio_host

// ===== sim/pmr_mii_mgmt_test.sv
// self-checking bench for the phy management register bank
module pmr_mii_mgmt_test;
    timeunit 1ns;
    timeprecision 1ns;
    import pmr_pkg::*;

    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic mdc, mdio_pin, mdio_o, mdio_oe;
    logic [1:0] link_up, an_done, fiber, far_fault, lp_capture, cable_done, cable_short, cable_start;
    logic [9:0] lp_ability;
    logic [3:0] cable_result;
    logic [17:0] cable_count;
    logic [11:0] adv_ability;
    pmr_word_type rd;
    int errors = 0;
    int num_checks = 0;
    int starts = 0;

    always #50 sys_clk = ~sys_clk;

    // count test start pulses of port one
    always @(posedge sys_clk) if (cable_start[0] === 1'b1) starts <= starts + 1;

    pmr_mii_mgmt uut (.sys_clk_i(sys_clk), .rst_n_i(rst_n), .mdc_i(mdc), .mdio_i(mdio_pin),
        .mdio_o(mdio_o), .mdio_oe_o(mdio_oe), .link_up_i(link_up), .an_done_i(an_done),
        .fiber_mode_i(fiber), .far_fault_i(far_fault), .lp_capture_i(lp_capture),
        .lp_ability_i(lp_ability), .cable_done_i(cable_done), .cable_result_i(cable_result),
        .cable_short_i(cable_short), .cable_count_i(cable_count), .cable_start_o(cable_start),
        .adv_ability_o(adv_ability));

    pmr_mdio_host host (.sys_clk_i(sys_clk), .mdio_o(mdio_o), .mdio_oe_o(mdio_oe), .mdc_o(mdc),
        .mdio_pin_o(mdio_pin));

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic rd_reg(input logic [4:0] pa, input logic [4:0] ra);
        host.frame(2'b10, pa, ra, 16'h0000, rd);
    endtask

    // write, then let the write strobe land
    task automatic wr_reg(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd);
        pmr_word_type dummy;
        host.frame(2'b01, pa, ra, wd, dummy);
        repeat (4) @(posedge sys_clk);
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic test_reset_values;
        rd_reg(5'h01, 5'h01);
        check("status", rd, 16'h7808);
        rd_reg(5'h01, 5'h02);
        check("id high", rd, 16'hA5C3);
        rd_reg(5'h02, 5'h03);
        check("id low", rd, 16'h3C5A);
        rd_reg(5'h02, 5'h04);
        check("adv", rd, 16'h05E1);
        rd_reg(5'h01, 5'h05);
        check("partner", rd, 16'h0001);
        rd_reg(5'h01, 5'h1D);
        check("cable", rd, 16'h0000);
        check("adv pins", {4'h0, adv_ability}, 16'h0BEF);
        $display("test reset values done");
    endtask

    task automatic test_status_live;
        @(posedge sys_clk);
        link_up <= 2'b10;
        an_done <= 2'b10;
        fiber <= 2'b10;
        far_fault <= 2'b10;
        rd_reg(5'h02, 5'h01);
        check("status two", rd, 16'h783C);
        rd_reg(5'h01, 5'h01);
        check("status one", rd, 16'h7808);
        fiber <= 2'b00;
        rd_reg(5'h02, 5'h01);
        check("status copper", rd, 16'h782C);
        $display("test status live done");
    endtask

    task automatic test_writes;
        wr_reg(5'h01, 5'h04, 16'hFFFF);
        rd_reg(5'h01, 5'h04);
        check("adv ones", rd, 16'h07E1);
        check("adv pins ones", {4'h0, adv_ability}, 16'h0BFF);
        wr_reg(5'h01, 5'h04, 16'h0000);
        rd_reg(5'h01, 5'h04);
        check("adv zeros", rd, 16'h0001);
        check("adv pins zeros", {4'h0, adv_ability}, 16'h0BC0);
        wr_reg(5'h01, 5'h01, 16'h0000);
        rd_reg(5'h01, 5'h01);
        check("status ro", rd, 16'h7808);
        wr_reg(5'h02, 5'h02, 16'h0000);
        rd_reg(5'h02, 5'h02);
        check("id ro", rd, 16'hA5C3);
        rd_reg(5'h03, 5'h01);
        check("no such phy", rd, 16'hFFFF);
        rd_reg(5'h01, 5'h1F);
        check("unmapped", rd, 16'h0000);
        $display("test writes done");
    endtask

    task automatic test_partner;
        @(posedge sys_clk);
        lp_ability <= 10'b00000_10101;
        lp_capture <= 2'b01;
        @(posedge sys_clk);
        lp_capture <= 2'b00;
        rd_reg(5'h01, 5'h05);
        check("partner one", rd, 16'h04A1);
        rd_reg(5'h02, 5'h05);
        check("partner two", rd, 16'h0001);
        $display("test partner done");
    endtask

    task automatic test_cable;
        logic [1:0] c;
        logic [15:0] exp;
        int s0;
        exp = 16'h0000;
        for (int code = 0; code < 4; code++) begin
            c = code[1:0];
            s0 = starts;
            wr_reg(5'h01, 5'h1D, 16'h8000);
            check("start pulses", 16'(starts - s0), 16'h0001);
            rd_reg(5'h01, 5'h1D);
            check("running", rd, {1'b1, exp[14:0]});
            @(posedge sys_clk);
            cable_result <= {2'b00, c};
            cable_short <= {1'b0, c == 2'b10};
            cable_count <= {9'h000, 9'h1FF - 9'(code)};
            cable_done <= 2'b01;
            @(posedge sys_clk);
            cable_done <= 2'b00;
            exp = {1'b0, c, c == 2'b10, 3'b000, 9'h1FF - 9'(code)};
            rd_reg(5'h01, 5'h1D);
            check("result", rd, exp);
        end
        $display("test cable done");
    endtask

    // watchdog against a hung run
    initial begin
        repeat (90000) @(posedge sys_clk);
        errors++;
        close_out();
    end

    initial begin
        {link_up, an_done, fiber, far_fault, lp_capture, cable_done, cable_short} = 14'h0000;
        lp_ability = 10'h000;
        cable_result = 4'h0;
        cable_count = 18'h00000;
        repeat (16) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        test_reset_values();
        test_status_live();
        test_writes();
        test_partner();
        test_cable();
        close_out();
    end
endmodule // pmr_mii_mgmt_test
